// file: design/lfad_map.vh
// register map, field layout, command codes and timing counts of the antenna driver
`ifndef LFAD_MAP_VH
`define LFAD_MAP_VH
// frame layout
`define LFAD_FRAME_W      64
`define LFAD_CMD_W        8
`define LFAD_DATA_W       56
// command codes in command byte bits 6..4
`define LFAD_CMD_NOP      3'h0
`define LFAD_CMD_CFG      3'h1
`define LFAD_CMD_CSR      3'h2
`define LFAD_CMD_BUF1     3'h3
`define LFAD_CMD_BUF2     3'h4
`define LFAD_CMD_START    3'h5
// configuration word field positions (lsb)
`define LFAD_CFG_CLKDIV   0
`define LFAD_CFG_BAUD     2
`define LFAD_CFG_OUTMODE  3
`define LFAD_CFG_PRIMARY_AMPLITUDE    19
`define LFAD_CFG_SECONDARY_AMPLITUDE    24
`define LFAD_CFG_DGAIN    29
`define LFAD_CFG_G2CNT    33
`define LFAD_CFG_G2BITS   39
`define LFAD_CFG_DSTART   46
`define LFAD_CFG_DLEN     52
`define LFAD_CFG_AUTO     54
`define LFAD_CFG_SLEEP    55
// configuration reset value
`define LFAD_CFG_RESET    56'hC0_8001_2DD8_0007
// control/status word field positions (lsb)
`define LFAD_CSR_TMR1     0
`define LFAD_CSR_CAL1     9
`define LFAD_CSR_TMR2     10
`define LFAD_CSR_CAL2     19
`define LFAD_CSR_TRIG1    20
`define LFAD_CSR_TRIG2    21
`define LFAD_CSR_OSEL1    22
`define LFAD_CSR_BUSY     25
`define LFAD_CSR_SLEEPST  27
// writable control/status reset value
`define LFAD_CSR_RESET    25'h000_0401
`define LFAD_CSR_WMASK    25
// measurement timer figures in ns and the 200 MHz period
`define LFAD_TMR_BASE_NS  250
`define LFAD_TMR_STEP_NS  500
`define LFAD_CLK_NS       5
`define LFAD_TMR_BASE_CYC (`LFAD_TMR_BASE_NS / `LFAD_CLK_NS)
`define LFAD_TMR_STEP_CYC (`LFAD_TMR_STEP_NS / `LFAD_CLK_NS)
// destroy start floor
`define LFAD_DSTART_MIN   6'h02
`endif

// file: design/lfad_fifo.v
// small fifo carrying completed frames from the serial front end to the register bank
`timescale 1ns/10ps
`default_nettype none
module lfad_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clock_in,
	input  wire             rst_b_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	output wire [WIDTH-1:0] rd_data_out,
	output wire             rd_valid_out,
	input  wire             rd_ready_in
);
	// ------------------------------------------------------------
	// storage and pointers
	// ------------------------------------------------------------
	reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // flip-flop storage
	reg [AW-1:0]    wptr_r;            // write index
	reg [AW-1:0]    rptr_r;            // read index
	reg [AW:0]      count_r;           // occupancy
	wire            push;
	wire            pop;
	assign wr_ready_out = (count_r != DEPTH[AW:0]);
	assign rd_valid_out = (count_r != {(AW+1){1'b0}});
	assign rd_data_out  = mem_r[rptr_r];
	assign push = wr_valid_in & wr_ready_out;
	assign pop  = rd_valid_out & rd_ready_in;
	// storage is not reset; only pointers and count carry state
	always @(posedge clock_in) begin
		if (push) begin
			mem_r[wptr_r] <= wr_data_in;
		end
	end
	// pointer and count update
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wptr_r  <= {AW{1'b0}};
			rptr_r  <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_r <= (wptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= (rptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // lfad_fifo
`default_nettype wire

// file: design/lfad_core.v
// serial register bank and bit sequencer of the low-frequency antenna driver
// Notes on behaviour
// - 64-bit frame: 8 command, 56 data
// - two 56-bit buffers, each own command
// - reload only inactive buffer while sending
// - clock divider codes 1, 2, 4, 8
// - baud select 7.8 or 15.6 kHz
// - per-output 2-bit drive mode
// - two 5-bit gains, n+1 volts
// - destroy gain 4-bit, reset 1001
// - bytes at first gain before switching
// - bits sent at second gain
// - destroy start, 0 or 1 means 2
// - destroy length code plus one bits
// - auto start when buffer one full
// - start command only without auto mode
// - sleep holds all outputs tri-state
// - measure delay 250 ns plus 500 ns steps
// - first trigger on odd data edges
// - second trigger on even data edges
// - output select for first measurement
`timescale 1ns/10ps
`default_nettype none
`include "lfad_map.vh"
module lfad_core #(
	parameter BAUD_LO_DIV = 3205, // one less than the divided clocks per bit at low baud
	parameter BAUD_HI_DIV = 1602, // one less than the divided clocks per bit at high baud
	parameter FIFO_DEPTH  = 8
) (
	input  wire        clock_in,
	input  wire        rst_b_in,
	input  wire        frame_select_low_in, // active-low frame select pin
	input  wire        sclk_in,             // serial clock pin
	input  wire        sdi_in,              // serial data in pin
	output reg         sdo_out,             // serial data out
	output reg         sdo_oe_b_out,        // low while driving sdo
	output reg  [7:0]  hs_on_out,           // high-side gate per output
	output reg  [7:0]  ls_on_out,           // low-side gate per output
	output reg  [7:0]  out_oe_b_out,        // low while output driven
	output reg  [4:0]  amplitude_out,       // present amplitude code
	output reg         destroy_out,         // destroy bit in progress
	output reg         meas1_strobe_out,    // first current sample
	output reg         meas2_strobe_out,    // second current sample
	output reg  [2:0]  meas1_sel_out        // output sampled first
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	reg [2:0] s1_r; // first stage, read only by second
	reg [2:0] s2_r; // second stage
	reg [2:0] s3_r; // edge history
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_r <= 3'h1;
			s2_r <= 3'h1;
			s3_r <= 3'h1;
		end else begin
			s1_r <= {sdi_in, sclk_in, frame_select_low_in};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	wire cs_b    = s2_r[0];
	wire cs_fall = s3_r[0] & ~s2_r[0];
	wire cs_rise = ~s3_r[0] & s2_r[0];
	wire sck_rise = ~s3_r[1] & s2_r[1] & ~cs_b;
	wire sck_fall = s3_r[1] & ~s2_r[1] & ~cs_b;
	// ------------------------------------------------------------
	// serial shift frame
	// ------------------------------------------------------------
	reg  [63:0] shift_r;   // serial_shift_frame
	reg  [6:0]  bitcnt_r;  // bits received in frame
	reg  [63:0] resp_r;    // reply loaded at frame start
	reg  [7:0]  last_cmd_r;// previous command echoed
	wire        f_ready;
	wire [63:0] f_data;
	wire        f_valid;
	reg         f_pop;
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_r      <= 64'h0000_0000_0000_0000;
			bitcnt_r     <= 7'h00;
			sdo_out      <= 1'b0;
			sdo_oe_b_out <= 1'b1;
		end else begin
			sdo_oe_b_out <= cs_b;
			if (cs_fall) begin
				// reply word loaded on select edge
				shift_r  <= resp_r;
				bitcnt_r <= 7'h00;
			end else if (sck_rise) begin
				sdo_out <= shift_r[63];
			end else if (sck_fall && bitcnt_r != 7'h40) begin
				shift_r  <= {shift_r[62:0], s2_r[2]};
				bitcnt_r <= bitcnt_r + 7'h01;
			end
		end
	end
	// only frames of at least 64 bits enter the fifo; short ones are dropped, long ones keep their first 64 bits
	wire f_push = cs_rise & (bitcnt_r == 7'h40);
	lfad_fifo #(
		.WIDTH (64),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.clock_in     (clock_in),
		.rst_b_in     (rst_b_in),
		.wr_data_in   (shift_r),
		.wr_valid_in  (f_push),
		.wr_ready_out (f_ready),
		.rd_data_out  (f_data),
		.rd_valid_out (f_valid),
		.rd_ready_in  (f_pop)
	);
	// ------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------
	reg  [55:0] buf1_r;      // transmit_buffer_one
	reg  [55:0] buf2_r;      // transmit_buffer_two
	reg  [55:0] cfg_r;       // driver_configuration
	reg  [24:0] csw_r;       // control_status_word, writable part
	reg         full1_r;     // buffer one loaded
	reg         full2_r;     // buffer two loaded
	reg         active_r;    // buffer in use, 0 = one
	reg         busy_r;      // transmission running
	reg         start_r;     // start request pulse
	reg  [55:0] prog_r;      // last programmed register
	wire        buf_done1;   // last bit of buffer one sent
	wire        buf_done2;   // last bit of buffer two sent
	wire [2:0]  f_op = f_data[62:60];
	wire        bank_tick;
	// the bank runs on the divided clock; frames wait in the fifo meanwhile
	always @* begin
		f_pop = f_valid & bank_tick;
	end
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			buf1_r     <= 56'h00_0000_0000_0000;
			buf2_r     <= 56'h00_0000_0000_0000;
			cfg_r      <= `LFAD_CFG_RESET;
			csw_r      <= `LFAD_CSR_RESET;
			full1_r    <= 1'b0;
			full2_r    <= 1'b0;
			start_r    <= 1'b0;
			prog_r     <= 56'h00_0000_0000_0000;
			last_cmd_r <= 8'h00;
		end else begin
			start_r <= 1'b0;
			if (buf_done1) begin
				full1_r <= 1'b0;
			end
			if (buf_done2) begin
				full2_r <= 1'b0;
			end
			if (f_pop) begin
				last_cmd_r <= f_data[63:56];
				case (f_op)
				`LFAD_CMD_CFG: begin
					cfg_r  <= f_data[55:0];
					prog_r <= f_data[55:0];
				end
				`LFAD_CMD_CSR: begin
					csw_r <= f_data[24:0];
				end
				`LFAD_CMD_BUF1: begin
					if (!(busy_r && active_r == 1'b0)) begin
						buf1_r  <= f_data[55:0];
						prog_r  <= f_data[55:0];
						full1_r <= 1'b1;
					end
				end
				`LFAD_CMD_BUF2: begin
					if (!(busy_r && active_r == 1'b1)) begin
						buf2_r  <= f_data[55:0];
						prog_r  <= f_data[55:0];
						full2_r <= 1'b1;
					end
				end
				`LFAD_CMD_START: begin
					start_r <= ~cfg_r[`LFAD_CFG_AUTO];
				end
				default: begin
					prog_r <= prog_r;
				end
				endcase
			end
		end
	end
	// reply: status word if msb set or after csr or start command, else programmed register, zero for plain nop
	wire [55:0] csr_view = {28'h000_0000, cfg_r[`LFAD_CFG_SLEEP], busy_r, active_r, csw_r};
	always @* begin
		if (last_cmd_r[7] || last_cmd_r[6:4] == `LFAD_CMD_CSR
			|| last_cmd_r[6:4] == `LFAD_CMD_START) begin
			resp_r = {last_cmd_r, csr_view};
		end else if (last_cmd_r[6:4] == `LFAD_CMD_NOP) begin
			resp_r = {last_cmd_r, 56'h00_0000_0000_0000};
		end else begin
			resp_r = {last_cmd_r, prog_r};
		end
	end
	// ------------------------------------------------------------
	// clock divider and bit timing
	// ------------------------------------------------------------
	reg [2:0]  div_r;  // input clock prescaler
	reg [11:0] baud_r; // divided clocks within a bit
	reg        bit_tick_r;
	// divide by 1, 2, 4, 8
	assign bank_tick = ((div_r & ((3'h1 << cfg_r[1:0]) - 3'h1)) == 3'h0);
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_r      <= 3'h0;
			baud_r     <= 12'h000;
			bit_tick_r <= 1'b0;
		end else begin
			div_r      <= div_r + 3'h1;
			bit_tick_r <= 1'b0;
			if (bank_tick) begin
				if (baud_r >= (cfg_r[`LFAD_CFG_BAUD] ? BAUD_HI_DIV[11:0] : BAUD_LO_DIV[11:0])) begin
					baud_r     <= 12'h000;
					bit_tick_r <= 1'b1;
				end else begin
					baud_r <= baud_r + 12'h001;
				end
			end
		end
	end
	// ------------------------------------------------------------
	// bit sequencer
	// ------------------------------------------------------------
	reg [5:0] bitpos_r;   // bit within buffer
	reg [5:0] bytes_r;    // bytes sent at first gain
	reg [6:0] g2bits_r;   // bits sent at second gain
	reg [5:0] normal_r;   // normal bits since destroy
	reg [1:0] dcnt_r;     // destroy bits remaining
	reg       in_dest_r;  // sending destroy bits
	reg       data_r;     // present data bit
	reg [2:0] edge_r;     // data edges counted
	wire [55:0] act_buf   = active_r ? buf2_r : buf1_r;
	assign buf_done1 = busy_r & bit_tick_r & ~in_dest_r & bitpos_r == 6'd55 & ~active_r;
	assign buf_done2 = busy_r & bit_tick_r & ~in_dest_r & bitpos_r == 6'd55 & active_r;
	wire [5:0]  dstart = (cfg_r[51:46] < `LFAD_DSTART_MIN) ? `LFAD_DSTART_MIN : cfg_r[51:46];
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_r    <= 1'b0;
			active_r  <= 1'b0;
			bitpos_r  <= 6'h00;
			bytes_r   <= 6'h00;
			g2bits_r  <= 7'h00;
			normal_r  <= 6'h00;
			dcnt_r    <= 2'h0;
			in_dest_r <= 1'b0;
			data_r    <= 1'b0;
		end else if (!busy_r) begin
			if (full1_r && (cfg_r[`LFAD_CFG_AUTO] || start_r)) begin
				busy_r   <= 1'b1;
				active_r <= 1'b0;
				bitpos_r <= 6'h00;
				bytes_r  <= 6'h00;
				g2bits_r <= 7'h00;
				normal_r <= 6'h00;
				// a burst armed on the last bit of a stopped run must not leak
				in_dest_r <= 1'b0;
				dcnt_r    <= 2'h0;
			end
		end else if (bit_tick_r) begin
			if (in_dest_r) begin
				if (dcnt_r == 2'h0) begin
					in_dest_r <= 1'b0;
				end else begin
					dcnt_r <= dcnt_r - 2'h1;
				end
			end else begin
				data_r <= act_buf[6'd55 - bitpos_r];
				if (bitpos_r[2:0] == 3'h7 && bytes_r != cfg_r[38:33]) begin
					bytes_r <= bytes_r + 6'h01;
				end
				if (bytes_r == cfg_r[38:33] && g2bits_r != cfg_r[45:39]) begin
					g2bits_r <= g2bits_r + 7'h01;
				end
				if (normal_r + 6'h01 >= dstart) begin
					normal_r  <= 6'h00;
					in_dest_r <= 1'b1;
					dcnt_r    <= cfg_r[53:52];
				end else begin
					normal_r <= normal_r + 6'h01;
				end
				if (bitpos_r == 6'd55) begin
					bitpos_r <= 6'h00;
					active_r <= ~active_r;
					// stop when the next buffer was not refilled
					busy_r   <= active_r ? full1_r : full2_r;
				end else begin
					bitpos_r <= bitpos_r + 6'h01;
				end
			end
		end
	end
	// ------------------------------------------------------------
	// output stage and measurement timing
	// ------------------------------------------------------------
	reg        data_d_r;  // delayed data for edges
	reg        m1_pend_r; // first sample armed
	reg        m2_pend_r; // second sample armed
	reg [15:0] m_cnt_r;   // shared delay counter
	reg [15:0] m_goal_r;  // delay target in cycles
	wire       d_rise = data_r & ~data_d_r;
	wire       d_fall = ~data_r & data_d_r;
	wire [4:0] tm1 = csw_r[4:0];
	wire [4:0] tm2 = csw_r[14:10];
	// delay targets in clocks, cut to the counter width on purpose
	wire [31:0] goal1 = `LFAD_TMR_BASE_CYC + tm1 * `LFAD_TMR_STEP_CYC;
	wire [31:0] goal2 = `LFAD_TMR_BASE_CYC + tm2 * `LFAD_TMR_STEP_CYC;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_out
			wire [1:0] mode = cfg_r[`LFAD_CFG_OUTMODE + 2*gi +: 2];
			always @(posedge clock_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					hs_on_out[gi]    <= 1'b0;
					ls_on_out[gi]    <= 1'b0;
					out_oe_b_out[gi] <= 1'b1;
				end else begin
					out_oe_b_out[gi] <= cfg_r[`LFAD_CFG_SLEEP];
					case (mode)
					2'h0: begin
						hs_on_out[gi] <= 1'b0;
						ls_on_out[gi] <= 1'b1;
					end
					2'h1: begin
						hs_on_out[gi] <= busy_r & ~in_dest_r & ~data_r;
						ls_on_out[gi] <= ~(busy_r & ~in_dest_r & ~data_r);
					end
					2'h2: begin
						hs_on_out[gi] <= busy_r & ~in_dest_r & data_r;
						ls_on_out[gi] <= ~(busy_r & ~in_dest_r & data_r);
					end
					default: begin
						hs_on_out[gi] <= busy_r & in_dest_r;
						ls_on_out[gi] <= ~(busy_r & in_dest_r);
					end
					endcase
				end
			end
		end
	endgenerate
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			amplitude_out    <= 5'h00;
			destroy_out      <= 1'b0;
			meas1_sel_out    <= 3'h0;
			data_d_r         <= 1'b0;
			edge_r           <= 3'h0;
			m1_pend_r        <= 1'b0;
			m2_pend_r        <= 1'b0;
			m_cnt_r          <= 16'h0000;
			m_goal_r         <= 16'h0000;
			meas1_strobe_out <= 1'b0;
			meas2_strobe_out <= 1'b0;
		end else begin
			data_d_r         <= data_r;
			meas1_strobe_out <= 1'b0;
			meas2_strobe_out <= 1'b0;
			destroy_out      <= busy_r & in_dest_r;
			meas1_sel_out    <= csw_r[24:22];
			// gain switch-over, byte count, bit count
			if (in_dest_r) begin
				amplitude_out <= {1'b0, cfg_r[32:29]};
			end else if (bytes_r == cfg_r[38:33] && g2bits_r != cfg_r[45:39]) begin
				amplitude_out <= cfg_r[28:24];
			end else begin
				amplitude_out <= cfg_r[23:19];
			end
			if (!busy_r) begin
				edge_r <= 3'h0;
			end
			if (busy_r && edge_r != 3'h6 && !m1_pend_r && !m2_pend_r) begin
				if (!edge_r[0] && (csw_r[`LFAD_CSR_TRIG1] ? d_fall : d_rise)) begin
					edge_r    <= edge_r + 3'h1;
					m1_pend_r <= 1'b1;
					m_cnt_r   <= 16'h0000;
					m_goal_r  <= goal1[15:0];
				end else if (edge_r[0] && (csw_r[`LFAD_CSR_TRIG2] ? d_fall : d_rise)) begin
					edge_r    <= edge_r + 3'h1;
					m2_pend_r <= 1'b1;
					m_cnt_r   <= 16'h0000;
					m_goal_r  <= goal2[15:0];
				end
			end
			if (m1_pend_r || m2_pend_r) begin
				m_cnt_r <= m_cnt_r + 16'h0001;
				if (m_cnt_r + 16'h0001 >= m_goal_r) begin
					meas1_strobe_out <= m1_pend_r;
					meas2_strobe_out <= m2_pend_r;
					m1_pend_r        <= 1'b0;
					m2_pend_r        <= 1'b0;
				end
			end
		end
	end
endmodule // lfad_core
`default_nettype wire

// file: sim/lfad_core_monitor.sv
// concurrent checks on the antenna driver core ports
`timescale 1ns/10ps
`default_nettype none
module lfad_core_monitor #(
	parameter BAUD_LO_DIV = 3205, // one less than the divided clocks per bit, low baud
	parameter BAUD_HI_DIV = 1602, // one less than the divided clocks per bit, high baud
	parameter FIFO_DEPTH  = 8     // frame fifo depth
) (
	input wire logic       clock_in,
	input wire logic       rst_b_in,
	input wire logic       frame_select_low_in,
	input wire logic       sclk_in,
	input wire logic       sdi_in,
	input wire logic       sdo_out,
	input wire logic       sdo_oe_b_out,
	input wire logic [7:0] hs_on_out,
	input wire logic [7:0] ls_on_out,
	input wire logic [7:0] out_oe_b_out,
	input wire logic [4:0] amplitude_out,
	input wire logic       destroy_out,
	input wire logic       meas1_strobe_out,
	input wire logic       meas2_strobe_out,
	input wire logic [2:0] meas1_sel_out
);
	// ----------------------------------------
	// clocking and reset
	// ----------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	reset_sleep_a: assert property ($rose(rst_b_in) |=> out_oe_b_out == 8'hFF)
		else $error("outputs not tri-state after reset");
	idle_lowside_a: assert property ($rose(rst_b_in) |=> ls_on_out == 8'hFF && hs_on_out == 8'h00)
		else $error("outputs not low side on after reset");
	// both gates of one half bridge on would short the supply
	no_shoot_a: assert property ((hs_on_out & ls_on_out) == 8'h00)
		else $error("high and low side on together");
	sdo_release_a: assert property (frame_select_low_in [*5] |-> sdo_oe_b_out)
		else $error("reply pin driven while not selected");
	sdo_drive_a: assert property (!frame_select_low_in [*5] |-> !sdo_oe_b_out)
		else $error("reply pin not driven while selected");
	strobe_one_a: assert property (meas1_strobe_out |=> !meas1_strobe_out)
		else $error("first sample strobe longer than one cycle");
	strobe_two_a: assert property (meas2_strobe_out |=> !meas2_strobe_out)
		else $error("second sample strobe longer than one cycle");
	// destroy gain is four bits, so the top amplitude bit must be clear
	destroy_gain_a: assert property (destroy_out [*3] |-> !amplitude_out[4])
		else $error("destroy amplitude wider than four bits");
	sel_update_a: assert property ($changed(meas1_sel_out) |-> $past(frame_select_low_in, 3))
		else $error("output select changed inside a frame");

	// ----------------------------------------
	// covers
	// ----------------------------------------
	cover property (meas1_strobe_out);
	cover property (meas2_strobe_out);
	cover property (destroy_out);
	cover property (out_oe_b_out == 8'h00);
endmodule // lfad_core_monitor

bind lfad_core lfad_core_monitor #(.BAUD_LO_DIV(BAUD_LO_DIV), .BAUD_HI_DIV(BAUD_HI_DIV),
	.FIFO_DEPTH(FIFO_DEPTH)) lfad_core_monitor_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
	.frame_select_low_in(frame_select_low_in), .sclk_in(sclk_in), .sdi_in(sdi_in),
	.sdo_out(sdo_out), .sdo_oe_b_out(sdo_oe_b_out), .hs_on_out(hs_on_out),
	.ls_on_out(ls_on_out), .out_oe_b_out(out_oe_b_out), .amplitude_out(amplitude_out),
	.destroy_out(destroy_out), .meas1_strobe_out(meas1_strobe_out),
	.meas2_strobe_out(meas2_strobe_out), .meas1_sel_out(meas1_sel_out));
`default_nettype wire

// file: sim/lfad_spi_master.sv
// serial link controller model that frames 64-bit words to the driver
`timescale 1ns/10ps
`default_nettype none
module lfad_spi_master (
	input wire logic  clock_in,             // system clock, steps on falling edge
	input wire logic  sdo_in,               // reply bit from the driver
	output var logic  frame_select_low_out, // active-low frame select
	output var logic  sclk_out,             // serial clock, still between frames
	output var logic  sdi_out               // serial data to the driver
);
	// idle: deselected, clock low
	initial begin
		frame_select_low_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end

	// ----------------------------------------
	// one whole frame, msb first
	// ----------------------------------------
	// exactly 64 bits
	task automatic xfer(input logic [63:0] tx, output logic [63:0] rx);
		integer i;
		begin
			// clock already low when select falls
			@(negedge clock_in);
			frame_select_low_out = 1'b0;
			repeat (5) @(negedge clock_in);
			for (i = 63; i >= 0; i--) begin
				sclk_out = 1'b1;
				sdi_out = tx[i];
				repeat (5) @(negedge clock_in);
				rx[i] = sdo_in;
				sclk_out = 1'b0;
				repeat (5) @(negedge clock_in);
			end
			frame_select_low_out = 1'b1;
			// released data line must not keep the last bit
			sdi_out = ~sdi_out;
			repeat (40) @(negedge clock_in);
		end
	endtask
endmodule // lfad_spi_master
`default_nettype wire

// file: sim/lf_antenna_driver_register_map_tb.sv
// self-checking bench for the antenna driver core
`timescale 1ns/10ps
`default_nettype none
module lf_antenna_driver_register_map_tb;
	// ----------------------------------------
	// stimulus values
	// ----------------------------------------
	// sleep off, auto off, destroy 2 bits after 20, gains 21/9, destroy gain 3
	localparam logic [55:0] CFG_W = {1'h0, 1'h0, 2'h1, 6'h14, 7'h00, 6'h3F, 4'h3,
		5'h09, 5'h15, 16'h00D2, 1'h1, 2'h0};
	// osel 2, trig2 fall, both calibration set, timers code 1 (150 cycles < bit)
	localparam logic [24:0] CSW_W = {3'h2, 1'h1, 1'h0, 1'h1, 9'h001, 1'h1, 9'h001};
	localparam logic [55:0] BUF1 = 56'h5A_C3F0_0F96_69A5;
	localparam logic [55:0] BUF2 = 56'h96_A55A_3CC3_F00F;
	logic        clock_in;           // 200 MHz
	logic        rst_b_in;           // async reset, active low
	wire         frame_select_low;   // select from controller model
	wire         sclk;               // serial clock
	wire         sdi;                // serial data in
	wire         sdo;                // reply bit
	wire [7:0]   hs_on;              // gate drives
	wire [7:0]   ls_on;
	wire [7:0]   out_oe_b;
	wire [4:0]   amplitude;
	wire         destroy;
	wire         meas1_strobe;
	wire         meas2_strobe;
	wire [2:0]   meas1_sel;
	logic [63:0] r;                  // reply of the previous frame
	integer      errors = 0;
	integer      n_compared = 0;
	integer      m1 = 0;             // first sample strobes seen
	integer      m2 = 0;             // second sample strobes seen
	integer      run = 0;            // current destroy burst length
	integer      last_run = 0;       // length of the last finished burst
	logic [4:0]  damp = 5'h00;       // amplitude mid destroy burst

	// ----------------------------------------
	// clock, reset, instances
	// ----------------------------------------
	initial clock_in = 1'b0;
	always #2.5 clock_in = ~clock_in;
	initial begin
		rst_b_in = 1'b0;
		repeat (10) @(negedge clock_in);
		rst_b_in = 1'b1;
	end
	lfad_core #(.BAUD_LO_DIV(400), .BAUD_HI_DIV(200), .FIFO_DEPTH(8)) lfad_core_i (
		.clock_in(clock_in), .rst_b_in(rst_b_in), .frame_select_low_in(frame_select_low),
		.sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_b_out(),
		.hs_on_out(hs_on), .ls_on_out(ls_on), .out_oe_b_out(out_oe_b),
		.amplitude_out(amplitude), .destroy_out(destroy), .meas1_strobe_out(meas1_strobe),
		.meas2_strobe_out(meas2_strobe), .meas1_sel_out(meas1_sel));
	lfad_spi_master lfad_spi_master_i (.clock_in(clock_in), .sdo_in(sdo),
		.frame_select_low_out(frame_select_low), .sclk_out(sclk), .sdi_out(sdi));

	// strobe and destroy burst bookkeeping
	always @(posedge clock_in) begin
		if (meas1_strobe === 1'b1) m1++;
		if (meas2_strobe === 1'b1) m2++;
		if (destroy === 1'b1) begin
			run++;
			if (run == 100) damp = amplitude;
		end else if (run != 0) begin
			last_run = run;
			run = 0;
		end
	end

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// two buffers of 56 bits at 201 cycles plus frames, with ample slack
	initial begin
		#(60000 * 5);
		errors++;
		$display("watchdog expired");
		wrap_up;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_reply;
		check("oe after reset", 64'hFF, out_oe_b);
		check("low side after reset", {8'hFF, 8'h00}, {ls_on, hs_on});
		check("gain one after reset", 5'h1B, amplitude);
		lfad_spi_master_i.xfer({8'h80, 56'h0}, r);
		check("first reply", 64'h0, r);
		lfad_spi_master_i.xfer(64'h0, r);
		check("status reset", 28'h800_0401, r[27:0]);
		$display("reset and reply test done");
	endtask
	task automatic t_config;
		lfad_spi_master_i.xfer({8'h10, CFG_W}, r);
		lfad_spi_master_i.xfer({8'h20, 31'h0, CSW_W}, r);
		check("config readback", {8'h10, CFG_W}, r);
		lfad_spi_master_i.xfer({8'h30, BUF1}, r);
		check("status readback", {1'h0, 2'h0, CSW_W}, r[27:0]);
		check("measure select", 3'h2, meas1_sel);
		check("oe awake", 8'h00, out_oe_b);
		check("idle gates", {8'hF2, 8'h00}, {ls_on & 8'hF2, hs_on & 8'hF2});
		$display("configuration test done");
	endtask
	task automatic t_transmit;
		lfad_spi_master_i.xfer({8'h80, 56'h0}, r);
		check("buffer one readback", {8'h30, BUF1}, r);
		lfad_spi_master_i.xfer({8'h50, 56'h0}, r);
		check("idle before start", 2'h0, r[26:25]);
		lfad_spi_master_i.xfer({8'h40, BUF2}, r);
		check("busy on buffer one", 2'h2, r[26:25]);
		check("first gain", 5'h15, amplitude);
		// reload of the active buffer must be dropped
		lfad_spi_master_i.xfer({8'h30, BUF2}, r);
		check("buffer two readback", {8'h40, BUF2}, r);
		repeat (10000) @(negedge clock_in);
		lfad_spi_master_i.xfer({8'h80, 56'h0}, r);
		lfad_spi_master_i.xfer(64'h0, r);
		check("busy on buffer two", 2'h3, r[26:25]);
		repeat (12000) @(negedge clock_in);
		lfad_spi_master_i.xfer({8'h80, 56'h0}, r);
		lfad_spi_master_i.xfer(64'h0, r);
		check("stopped unrefilled", 1'h0, r[26]);
		check("destroy length", 1'h1, last_run >= 390 && last_run <= 410);
		check("destroy gain", 5'h03, damp);
		check("first samples", 1'h1, m1 > 0);
		check("second samples", 1'h1, m2 > 0);
		$display("transmission test done");
	endtask

	// main sequence, reset then scenarios
	initial begin
		@(posedge rst_b_in);
		repeat (5) @(negedge clock_in);
		t_reset_reply;
		t_config;
		t_transmit;
		wrap_up;
	end
endmodule // lf_antenna_driver_register_map_tb
`default_nettype wire
